// file: logic/graphics_port_bridge_secondary_cfg.sv
// Secondary side configuration, window decode and tenure-limited master of the graphics port
`timescale 1ns/1ns
`default_nettype none
module graphics_port_bridge_secondary_cfg
  import gport_cfg_pkg::*;
(
  input wire logic ref_clk, // Block clock, 25 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire cfg_req_s cfgReq, // Configuration byte access
  output logic [7:0] cfgRdData, // Read data
  output logic cfgRdValid, // Read data valid pulse
  input wire logic [7:0] cfgBusQuery, // Target bus of a configuration cycle
  input wire logic [15:0] ioAddrQuery, // Host I/O address
  output logic cfgToGraphics, // Configuration cycle goes to graphics bus
  output logic ioToGraphics, // I/O access goes to graphics bus
  input wire logic burstStart, // Request a master burst
  input wire logic [7:0] burstWords, // Data phases wanted, zero means one
  output logic burstBusy, // Burst pending or running
  output logic burstDone, // Burst finished pulse
  output logic burstAbort, // Burst ended by an abort pulse
  output logic tenureExpired, // Latency count used up
  input wire logic linkClk, // Graphics port clock pin
  input wire pin_in_s pinIn, // Graphics bus input pins
  output pin_out_s pinOut // Graphics bus output pins
);

  typedef struct packed {
    logic [7:0] secBus;
    logic [7:0] subBus;
    logic [7:0] latTimer;
    logic [7:0] ioBase;
    logic [7:0] ioLimit;
    logic parityErr;
    logic masterAbort;
    logic targetAbort;
    logic [7:0] rdData;
    logic rdValid;
    logic cfgHit;
    logic ioHit;
    master_e mst;
    logic pending;
    logic owned;
    logic [7:0] remaining;
    logic [2:0] devselWait;
    logic ending;
    logic done;
    logic abortP;
    pin_out_s pins;
  } state_s;

  state_s s_reg;
  state_s s_next;

  logic [5:0] syncPins;
  logic linkTick;
  logic gntN;
  logic devselN;
  logic trdyN;
  logic stopN;
  logic parErr;
  logic tenureLoad;
  logic expired;
  logic [7:0] latCount;
  logic yieldBus;

  // Status word assembled from flags and fixed fields
  function automatic logic [15:0] statusWord(input logic pe, input logic ma, input logic ta);
    logic [15:0] w;
    w = STS_FIXED;
    w[STS_PARITY_BIT] = pe;
    w[STS_MABORT_BIT] = ma;
    w[STS_TABORT_BIT] = ta;
    return w;
  endfunction

  // Inclusive window compare shared by the bus number and I/O decodes
  function automatic logic inWindow(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Sticky flag update; a hardware set beats a software clear in the same cycle
  function automatic logic stickyNext(input logic cur, input logic clear, input logic set);
    return (cur & ~clear) | set;
  endfunction

  // Readback of one configuration byte
  function automatic logic [7:0] readByte(input logic [7:0] a, input state_s st);
    logic [15:0] sts;
    // Flags and fixed fields merged before the byte is picked
    sts = statusWord(st.parityErr, st.masterAbort, st.targetAbort);
    if (a == OFF_SEC_BUS) begin
      return st.secBus;
    end else if (a == OFF_SUB_BUS) begin
      return st.subBus;
    end else if (a == OFF_LAT_TIMER) begin
      return st.latTimer;
    end else if (a == OFF_IO_BASE) begin
      return st.ioBase;
    end else if (a == OFF_IO_LIMIT) begin
      return st.ioLimit;
    end else if (a == OFF_STS_LO) begin
      return sts[7:0];
    end else if (a == OFF_STS_HI) begin
      return sts[15:8];
    end else begin
      return UNMAPPED_READ;
    end
  endfunction

  // Link clock and pins cross into the block clock together
  link_sync #(
    .W(6)
  ) pinSync (
    .ref_clk(ref_clk),
    .rst(rst),
    .din({
      linkClk, // Top bit: its edge becomes the link tick
      pinIn.gntN,
      pinIn.devselN,
      pinIn.trdyN,
      pinIn.stopN,
      pinIn.parErr
    }),
    .dout(syncPins),
    .rise(linkTick)
  );

  // Synchronised pin views, sampled one block clock after the linkClk sample that raised the tick
  assign gntN = syncPins[4];
  assign devselN = syncPins[3];
  assign trdyN = syncPins[2];
  assign stopN = syncPins[1];
  assign parErr = syncPins[0];

  // Low three timer bits never reach the counter
  assign latCount = s_reg.latTimer & LAT_FIELD_MASK;

  // Tenure used up and grant gone: the bus must be handed back
  assign yieldBus = expired && gntN;

  // Counter is loaded on the frame that opens a fresh tenure
  assign tenureLoad = linkTick && s_reg.mst == M_IDLE && s_reg.pending
    && !gntN && !s_reg.owned;

  // Counts link ticks only, so the limit is in graphics port clocks
  tenure_counter #(
    .W(8)
  ) tenure (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(tenureLoad),
    .tick(linkTick),
    .loadVal(latCount),
    .expired(expired)
  );

  // Next state: registers, decode, status flags and master sequence
  always_comb begin
    logic [15:0] clr;
    logic setPe;
    logic setMa;
    logic setTa;
    logic abortNow;
    clr = 16'h0000;
    setPe = 1'b0;
    setMa = 1'b0;
    setTa = 1'b0;
    abortNow = 1'b0;
    s_next = s_reg;
    // Pulses stand for one cycle only
    s_next.rdValid = 1'b0;
    s_next.done = 1'b0;
    s_next.abortP = 1'b0;

    // Configuration writes; reserved bits stay zero
    if (cfgReq.wr) begin
      if (cfgReq.addr == OFF_SEC_BUS) begin
        s_next.secBus = cfgReq.data;
      end else if (cfgReq.addr == OFF_SUB_BUS) begin
        s_next.subBus = cfgReq.data;
      end else if (cfgReq.addr == OFF_LAT_TIMER) begin
        s_next.latTimer = cfgReq.data;
      end else if (cfgReq.addr == OFF_IO_BASE) begin
        s_next.ioBase = cfgReq.data & IO_FIELD_MASK;
      end else if (cfgReq.addr == OFF_IO_LIMIT) begin
        s_next.ioLimit = cfgReq.data & IO_FIELD_MASK;
      end else if (cfgReq.addr == OFF_STS_HI) begin
        clr = {cfgReq.data, 8'h00} & STS_W1C_MASK;
      end
    end

    // Reads answer one cycle after the request
    if (cfgReq.rd) begin
      s_next.rdData = readByte(cfgReq.addr, s_reg);
      s_next.rdValid = 1'b1;
    end

    // Window decodes, registered for a clean output
    s_next.cfgHit = inWindow({8'h00, cfgBusQuery}, {8'h00, s_reg.secBus},
      {8'h00, s_reg.subBus});
    s_next.ioHit = inWindow(ioAddrQuery, {s_reg.ioBase[7:4], IO_BASE_LOW},
      {s_reg.ioLimit[7:4], IO_LIMIT_LOW});

    // Accept a burst only when nothing is pending
    if (burstStart && !s_reg.pending && s_reg.mst == M_IDLE) begin
      s_next.pending = 1'b1;
      s_next.remaining = (burstWords == 8'h00) ? 8'h01 : burstWords;
    end

    // Master sequence advances on link clock edges only
    if (linkTick) begin
      // Ownership lasts exactly as long as the grant
      if (gntN) begin
        s_next.owned = 1'b0;
      end
      // Parity is judged only while the bridge runs a cycle
      if (s_reg.mst != M_IDLE && parErr) begin
        setPe = 1'b1;
      end
      case (s_reg.mst)
        M_IDLE: begin
          // Grant seen with a request pending opens the frame
          if (s_reg.pending && !gntN) begin
            s_next.mst = M_ADDR;
            s_next.owned = 1'b1;
            s_next.pins.frameN = 1'b0;
            s_next.pins.frameOe = 1'b1;
            s_next.pins.irdyN = 1'b1;
            s_next.pins.irdyOe = 1'b1;
            s_next.pins.reqN = 1'b1;
          end
        end
        M_ADDR: begin
          // Address phase over; ready goes low for the first data phase
          s_next.mst = M_DATA;
          s_next.pins.irdyN = 1'b0;
          s_next.devselWait = 3'h0;
          // A single phase burst drops frame with the first data phase
          if (s_reg.remaining == 8'h01) begin
            s_next.pins.frameN = 1'b1;
          end
        end
        M_DATA: begin
          if (s_reg.ending) begin
            // Frame went high a tick ago; ready follows so frame never rises alone
            s_next.pins.irdyN = 1'b1;
            s_next.ending = 1'b0;
            s_next.abortP = 1'b1;
            s_next.mst = M_TURN;
          end else if (!stopN && devselN) begin
            // Stop without select is a target abort
            setTa = 1'b1;
            abortNow = 1'b1;
          end else if (devselN) begin
            // No target claimed the cycle in time
            s_next.devselWait = s_reg.devselWait + 3'h1;
            if (s_reg.devselWait == MABORT_TICKS - 3'h1) begin
              setMa = 1'b1;
              abortNow = 1'b1;
            end
          end else if (!trdyN) begin
            // A data phase completed on this tick
            s_next.remaining = s_reg.remaining - 8'h01;
            if (s_reg.pins.frameN) begin
              // Final transfer done with frame already negated
              s_next.pins.irdyN = 1'b1;
              s_next.mst = M_TURN;
            end else if (s_reg.remaining == 8'h02 || !stopN
              || yieldBus) begin
              s_next.pins.frameN = 1'b1;
            end
          end else if (!stopN && !s_reg.pins.frameN) begin
            // Disconnect without data: the next phase is the last
            s_next.pins.frameN = 1'b1;
          end else if (!stopN) begin
            // Stop with frame already high ends the cycle here
            s_next.pins.irdyN = 1'b1;
            s_next.mst = M_TURN;
          end
        end
        M_TURN: begin
          // Pins were driven high for one clock, now released
          s_next.pins.frameOe = 1'b0;
          s_next.pins.irdyOe = 1'b0;
          s_next.pending = 1'b0;
          s_next.done = 1'b1;
          s_next.mst = M_IDLE;
        end
        default: begin
          s_next.mst = M_IDLE;
        end
      endcase

      // Aborts drop frame first and release ready one tick later
      if (abortNow) begin
        s_next.pins.frameN = 1'b1;
        s_next.ending = 1'b1;
      end
    end

    // Request stands from acceptance until the frame opens
    s_next.pins.reqN = ~(s_next.pending && s_next.mst == M_IDLE);

    // Hardware set wins over a software clear in the same cycle
    s_next.parityErr = stickyNext(s_reg.parityErr, clr[STS_PARITY_BIT], setPe);
    s_next.masterAbort = stickyNext(s_reg.masterAbort, clr[STS_MABORT_BIT], setMa);
    s_next.targetAbort = stickyNext(s_reg.targetAbort, clr[STS_TABORT_BIT], setTa);
  end

  // State register with documented reset values
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.secBus <= RST_SEC_BUS;
      s_reg.subBus <= RST_SUB_BUS;
      s_reg.latTimer <= RST_LAT_TIMER;
      s_reg.ioBase <= RST_IO_BASE;
      s_reg.ioLimit <= RST_IO_LIMIT;
      s_reg.mst <= M_IDLE;
      s_reg.pins.reqN <= 1'b1;
      s_reg.pins.frameN <= 1'b1;
      s_reg.pins.irdyN <= 1'b1;
      s_reg.pins.frameOe <= 1'b0; // Bus released out of reset
      s_reg.pins.irdyOe <= 1'b0;
      s_reg.ending <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Every output except tenureExpired comes straight from the state register; tenureExpired comes from the tenure counter
  assign cfgRdData = s_reg.rdData;
  assign cfgRdValid = s_reg.rdValid;
  assign cfgToGraphics = s_reg.cfgHit;
  assign ioToGraphics = s_reg.ioHit;
  assign burstBusy = s_reg.pending;
  assign burstDone = s_reg.done;
  assign burstAbort = s_reg.abortP;
  assign tenureExpired = expired;
  assign pinOut = s_reg.pins;

endmodule
`default_nettype wire

// file: logic/gport_cfg_pkg.sv
// Constants, types and carriers for the graphics port secondary configuration block
package gport_cfg_pkg;

  // Configuration byte offsets
  localparam logic [7:0] OFF_SEC_BUS = 8'h19;
  localparam logic [7:0] OFF_SUB_BUS = 8'h1A;
  localparam logic [7:0] OFF_LAT_TIMER = 8'h1B;
  localparam logic [7:0] OFF_IO_BASE = 8'h1C;
  localparam logic [7:0] OFF_IO_LIMIT = 8'h1D;
  localparam logic [7:0] OFF_STS_LO = 8'h1E;
  localparam logic [7:0] OFF_STS_HI = 8'h1F;

  // Reset values
  localparam logic [7:0] RST_SEC_BUS = 8'h00;
  localparam logic [7:0] RST_SUB_BUS = 8'h00;
  localparam logic [7:0] RST_LAT_TIMER = 8'h00;
  localparam logic [7:0] RST_IO_BASE = 8'hF0;
  localparam logic [7:0] RST_IO_LIMIT = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Field layout
  localparam logic [7:0] LAT_FIELD_MASK = 8'hF8;
  localparam logic [7:0] IO_FIELD_MASK = 8'hF0;
  localparam logic [11:0] IO_BASE_LOW = 12'h000;
  localparam logic [11:0] IO_LIMIT_LOW = 12'hFFF;
  localparam int STS_PARITY_BIT = 15;
  localparam int STS_MABORT_BIT = 13;
  localparam int STS_TABORT_BIT = 12;
  localparam logic [15:0] STS_FIXED = 16'h02A0;
  localparam logic [15:0] STS_W1C_MASK = 16'hB000;

  // Timing: link clock rate and master abort wait in link clocks
  localparam int LINK_CLK_MHZ = 66;
  localparam logic [2:0] MABORT_TICKS = 3'h5;

  typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_TURN} master_e;

  // Configuration access carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } cfg_req_s;

  // Graphics bus pins seen by the block, all active low except parErr
  typedef struct packed {
    logic gntN;
    logic devselN;
    logic trdyN;
    logic stopN;
    logic parErr;
  } pin_in_s;

  // Graphics bus pins driven by the block
  typedef struct packed {
    logic reqN;
    logic frameN;
    logic irdyN;
    logic frameOe;
    logic irdyOe;
  } pin_out_s;

endpackage

// file: logic/link_sync.sv
// Two-flop synchroniser for link pins with rising edge detect on bit W-1
`timescale 1ns/1ns
`default_nettype none
module link_sync #(
  parameter int W = 6
) (
  input wire logic ref_clk, // Block clock
  input wire logic rst, // Synchronous reset
  input wire logic [W-1:0] din, // Asynchronous inputs
  output logic [W-1:0] dout, // Synchronised inputs
  output logic rise // Rising edge of dout[W-1]
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic prevTop;
    logic rise;
  } sync_s;

  sync_s s_reg;
  sync_s s_next;

  // First stage feeds only the second stage
  always_comb begin
    s_next = s_reg;
    s_next.meta = din;
    s_next.sync = s_reg.meta;
    s_next.prevTop = s_reg.sync[W-1];
    s_next.rise = s_reg.sync[W-1] & ~s_reg.prevTop;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.sync;
  assign rise = s_reg.rise;
endmodule
`default_nettype wire

// file: logic/tenure_counter.sv
// Bus tenure counter that counts link clock ticks down to expiry
`timescale 1ns/1ns
`default_nettype none
module tenure_counter #(
  parameter int W = 8
) (
  input wire logic ref_clk, // Block clock
  input wire logic rst, // Synchronous reset
  input wire logic load, // Start of tenure pulse
  input wire logic tick, // One link clock elapsed
  input wire logic [W-1:0] loadVal, // Tenure length in link clocks
  output logic expired // Tenure used up
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic armed;
    logic expired;
  } cnt_s;

  cnt_s s_reg;
  cnt_s s_next;

  // Zero length never arms, so the limit stays off
  always_comb begin
    s_next = s_reg;
    if (load) begin
      s_next.cnt = loadVal;
      s_next.armed = (loadVal != '0);
      s_next.expired = 1'b0;
    end else if (tick && s_reg.armed && s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 1'b1;
      s_next.expired = (s_reg.cnt == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign expired = s_reg.expired;
endmodule
`default_nettype wire

// file: test/gport_cfg_properties.sv
// Port-level assertions for the graphics port secondary configuration block
`timescale 1ns/1ns
`default_nettype none
module gport_cfg_properties
  import gport_cfg_pkg::*;
(
  input wire logic ref_clk, // Block clock
  input wire logic rst, // Synchronous reset
  input wire cfg_req_s cfgReq, // Config access
  input wire logic [7:0] cfgRdData, // Read data
  input wire logic cfgRdValid, // Read strobe
  input wire logic burstStart, // Burst request
  input wire logic burstBusy, // Burst running
  input wire logic burstDone, // Burst end pulse
  input wire logic burstAbort, // Abort pulse
  input wire pin_out_s pinOut // Bus outputs
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // One link tick is 8 block clocks; synchroniser jitter adds a few
  sequence abortSeen;
    burstAbort;
  endsequence
  sequence doneSoon;
    ##[1:12] burstDone;
  endsequence
  rd_answer_a: assert property (cfgReq.rd |=> cfgRdValid) else $error("read not answered");
  rd_cause_a: assert property (cfgRdValid |-> $past(cfgReq.rd)) else $error("stray read strobe");
  sts_low_a: assert property (cfgRdValid && $past(cfgReq.rd) && $past(cfgReq.addr) == OFF_STS_LO
    |-> cfgRdData == 8'hA0) else $error("status low byte wrong");
  sts_high_a: assert property (cfgRdValid && $past(cfgReq.rd) && $past(cfgReq.addr) == OFF_STS_HI
    |-> (cfgRdData & 8'h4F) == 8'h02) else $error("status fixed bits wrong");
  frame_end_a: assert property ($rose(pinOut.frameN) && pinOut.frameOe |-> !pinOut.irdyN)
    else $error("frame ended without final transfer");
  irdy_owned_a: assert property (!pinOut.irdyN |-> pinOut.irdyOe) else $error("ready not driven");
  start_req_a: assert property (burstStart && !burstBusy |=> burstBusy && !pinOut.reqN)
    else $error("start not taken");
  done_pulse_a: assert property (burstDone |=> !burstDone && !burstBusy) else $error("done not a pulse");
  abort_end_a: assert property (abortSeen |-> doneSoon) else $error("abort without end");
  bus_release_a: assert property (burstDone |-> !pinOut.frameOe && !pinOut.irdyOe)
    else $error("bus kept after end");
endmodule
`default_nettype wire

// file: test/gfx_target_model.sv
// Behavioural graphics bus arbiter and target facing the bridge master
`timescale 1ns/1ns
`default_nettype none
module gfx_target_model
  import gport_cfg_pkg::*;
(
  input wire logic linkClk, // Graphics port clock
  input wire pin_out_s pinOut, // Bridge outputs
  input wire logic [1:0] mode, // 0 claim, 1 silent, 2 target abort
  input wire logic dropGnt, // Withdraw the grant
  input wire logic perr, // Flag a parity error
  output pin_in_s pinIn, // Bridge inputs
  output int xfers // Data transfers seen
);
  logic inData;
  assign inData = pinOut.frameOe && (!pinOut.frameN || !pinOut.irdyN);
  initial begin
    pinIn = '{gntN: 1'b1, devselN: 1'b1, trdyN: 1'b1, stopN: 1'b1, parErr: 1'b0};
    xfers = 0;
  end
  // Drive on the falling edge; released lines float high on their pull-ups
  always @(negedge linkClk) begin
    pinIn.gntN <= dropGnt || (pinOut.reqN && !pinOut.frameOe);
    pinIn.devselN <= !(inData && mode == 2'd0);
    pinIn.trdyN <= !(inData && mode == 2'd0);
    pinIn.stopN <= !(inData && mode == 2'd2);
    pinIn.parErr <= perr && inData;
  end
  // Count completed data phases
  always @(posedge linkClk) begin
    if (!pinOut.irdyN && !pinIn.trdyN && pinOut.irdyOe) xfers <= xfers + 1;
  end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the graphics port secondary configuration block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gport_cfg_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic linkClk = 1'b0;
  cfg_req_s cfgReq = '0;
  logic [7:0] cfgBusQuery = 8'h00;
  logic [15:0] ioAddrQuery = 16'h0000;
  logic burstStart = 1'b0;
  logic [7:0] burstWords = 8'h00;
  logic [1:0] mode = 2'd0;
  logic dropGnt = 1'b0;
  logic perr = 1'b0;
  logic [7:0] cfgRdData, d, b;
  logic [15:0] a;
  logic cfgRdValid, cfgToGraphics, ioToGraphics, burstBusy, burstDone, burstAbort, tenureExpired;
  logic sawAbort = 1'b0, sawExpired = 1'b0;
  pin_in_s pinIn;
  pin_out_s pinOut;
  int xfers, base, n_mismatch = 0, tests_run = 0, cycles = 0, frameAt = 0, expireAt = 0;
  int seed = 32'h85DC9E95;
  logic [7:0] expq [$];

  graphics_port_bridge_secondary_cfg dut (.ref_clk, .rst, .cfgReq, .cfgRdData, .cfgRdValid, .cfgBusQuery,
    .ioAddrQuery, .cfgToGraphics, .ioToGraphics, .burstStart, .burstWords, .burstBusy, .burstDone,
    .burstAbort, .tenureExpired, .linkClk, .pinIn, .pinOut);
  gfx_target_model partner (.linkClk, .pinOut, .mode, .dropGnt, .perr, .pinIn, .xfers);

  initial forever #20 ref_clk = ~ref_clk;
  // Link clock free running, phase unrelated to the block clock
  initial begin
    #7;
    forever #160 linkClk = ~linkClk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Compares %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, far above the thousand or so cycles the run needs; burst events noted per burst
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (burstStart === 1'b1) begin
      sawAbort <= 1'b0;
      sawExpired <= 1'b0;
      frameAt <= 0;
    end else begin
      if (burstAbort === 1'b1) sawAbort <= 1'b1;
      if (tenureExpired === 1'b1 && sawExpired !== 1'b1) begin
        sawExpired <= 1'b1;
        expireAt <= cycles;
      end
      if (pinOut.frameN === 1'b0 && frameAt == 0) frameAt <= cycles;
    end
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  // Read data is compared against the oldest note when the strobe shows
  always @(negedge ref_clk) begin
    if (cfgRdValid === 1'b1) check("read data", cfgRdData, expq.pop_front());
  end

  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    @(negedge ref_clk) cfgReq = '{wr: 1'b1, rd: 1'b0, addr: ad, data: v};
    @(negedge ref_clk) cfgReq = '0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(negedge ref_clk) cfgReq = '{wr: 1'b0, rd: 1'b1, addr: ad, data: 8'h00};
    expq.push_back(e);
    @(negedge ref_clk) cfgReq = '0;
  endtask

  task automatic dec(input logic [7:0] qb, input logic [15:0] qa, input logic ec, input logic ei);
    @(negedge ref_clk) cfgBusQuery = qb;
    ioAddrQuery = qa;
    @(negedge ref_clk) check("cfg route", cfgToGraphics, ec);
    check("io route", ioToGraphics, ei);
  endtask

  task automatic burst(input logic [7:0] n);
    int k;
    k = 0;
    base = xfers;
    @(negedge ref_clk) burstStart = 1'b1;
    burstWords = n;
    @(negedge ref_clk) burstStart = 1'b0;
    while (burstDone !== 1'b1 && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
    check("burst end", k < 3000, 1'b1);
    repeat (16) @(negedge ref_clk);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    rd(OFF_SEC_BUS, 8'h00);
    rd(OFF_SUB_BUS, 8'h00);
    rd(OFF_LAT_TIMER, 8'h00);
    rd(OFF_IO_BASE, 8'hF0);
    rd(OFF_IO_LIMIT, 8'h00);
    rd(OFF_STS_LO, 8'hA0);
    rd(OFF_STS_HI, 8'h02);
    rd(8'h30, 8'h00);
    // Random contents; I/O window registers keep only their upper nibble
    for (int i = 0; i < 5; i++) begin
      d = 8'($random(seed));
      wr(OFF_SEC_BUS + 8'(i), d);
      rd(OFF_SEC_BUS + 8'(i), i > 2 ? d & 8'hF0 : d);
    end
    wr(OFF_STS_LO, 8'hFF);
    rd(OFF_STS_LO, 8'hA0);
    wr(OFF_SEC_BUS, 8'h05);
    wr(OFF_SUB_BUS, 8'h09);
    wr(OFF_IO_BASE, 8'h3F);
    wr(OFF_IO_LIMIT, 8'h5A);
    dec(8'h04, 16'h2FFF, 1'b0, 1'b0);
    dec(8'h05, 16'h3000, 1'b1, 1'b1);
    dec(8'h09, 16'h5FFF, 1'b1, 1'b1);
    dec(8'h0A, 16'h6000, 1'b0, 1'b0);
    for (int i = 0; i < 20; i++) begin
      {b, a} = 24'($random(seed));
      dec(b, a, b >= 8'h05 && b <= 8'h09, a >= 16'h3000 && a <= 16'h5FFF);
    end
    // Timer 07h counts as zero: no limit
    wr(OFF_LAT_TIMER, 8'h07);
    burst(8'd12);
    check("words", 16'(xfers - base), 16'd12);
    check("expired", sawExpired, 1'b0);
    // Limit of 8 ticks with the grant held: ownership kept
    wr(OFF_LAT_TIMER, 8'h0F);
    burst(8'd20);
    check("words", 16'(xfers - base), 16'd20);
    check("expired", sawExpired, 1'b1);
    // Eight ticks of eight block clocks from frame start to expiry
    check("tenure length", 16'(expireAt - frameAt), 16'd64);
    // Grant withdrawn mid burst: cut short after expiry
    fork
      burst(8'd20);
      begin
        repeat (40) @(negedge ref_clk);
        dropGnt = 1'b1;
      end
    join
    dropGnt = 1'b0;
    check("cut short", (xfers - base) inside {[4:10]}, 1'b1);
    mode = 2'd1;
    burst(8'd4);
    check("master abort", sawAbort, 1'b1);
    rd(OFF_STS_HI, 8'h22);
    wr(OFF_STS_HI, 8'h00);
    rd(OFF_STS_HI, 8'h22);
    wr(OFF_STS_HI, 8'hFF);
    rd(OFF_STS_HI, 8'h02);
    mode = 2'd2;
    burst(8'd4);
    rd(OFF_STS_HI, 8'h12);
    wr(OFF_STS_HI, 8'hFF);
    mode = 2'd0;
    perr = 1'b1;
    burst(8'd4);
    perr = 1'b0;
    rd(OFF_STS_HI, 8'h82);
    wr(OFF_STS_HI, 8'hFF);
    rd(OFF_STS_HI, 8'h02);
    repeat (4) @(negedge ref_clk);
    test_done();
  end
endmodule

bind graphics_port_bridge_secondary_cfg gport_cfg_properties props (.ref_clk, .rst, .cfgReq, .cfgRdData,
  .cfgRdValid, .burstStart, .burstBusy, .burstDone, .burstAbort, .pinOut);
`default_nettype wire
